// ===== rtl/wsd_pkg.sv
// constants shared by the weld step down counter
package wsd_pkg;
	// widths and limits
	localparam int          STEP_W         = 6;
	localparam int          COUNT_W        = 14;
	localparam int          OFF_W          = 7;
	localparam int          NUM_SCHED      = 50;
	localparam logic [5:0]  MAX_SCHED_IDX  = 6'h31;
	localparam logic [13:0] MAX_COUNT      = 14'h270f;
	localparam logic [6:0]  RESET_OFF_TIME = 7'h63;
	// fixed schedules started by the second and third initiation inputs
	localparam logic [5:0]  SECOND_SCHED   = 6'h0a;
	localparam logic [5:0]  THIRD_SCHED    = 6'h14;

	// register byte offsets
	localparam int          ADDR_W         = 5;
	localparam logic [4:0]  REG_CTRL       = 5'h00;
	localparam logic [4:0]  REG_LAST_STEP  = 5'h04;
	localparam logic [4:0]  REG_LAST_COUNT = 5'h08;
	localparam logic [4:0]  REG_STATUS     = 5'h0c;
	localparam logic [4:0]  REG_FIRST_STEP = 5'h10;
	localparam logic [4:0]  REG_SCHED_IDX  = 5'h14;
	localparam logic [4:0]  REG_SCHED_DATA = 5'h18;

	// field positions
	localparam int          CTRL_EXT_EN    = 0;
	localparam int          CTRL_PROG      = 1;
	localparam int          STAT_END       = 0;
	localparam int          STAT_SHOW      = 1;
	localparam int          SCHED_OFF_LSB  = 14;
	localparam int          SCHED_EMPTY    = 21;
	localparam int          SCHED_CHAIN_LSB = 22;

	// reset values
	localparam logic [1:0]  CTRL_RST       = 2'h0;
	localparam logic [5:0]  STEP_RST       = 6'h00;
	localparam logic [13:0] COUNT_RST      = 14'h0000;
	localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

	// display hold after a stepper reset
	localparam int          CLOCK_HZ       = 40000000;
	localparam int          SHOW_TIME_MS   = 500;
	localparam int          SHOW_CYCLES    = SHOW_TIME_MS * (CLOCK_HZ / 1000);
	localparam int          SHOW_CNT_W     = 25;
endpackage

// ===== rtl/wsd_panel_keys.sv
// front panel key decoder for the stepper reset chord and key presses
`timescale 1ns/1ps
module wsd_panel_keys (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic enterKey,
	input  wire logic dataLeftKey,
	input  wire logic dataRightKey,
	input  wire logic otherKey,
	input  wire logic programMode,
	output logic      manualReset,
	output logic      anyKeyPress
);
	logic chordFf;
	logic keysFf;
	logic chordNow;
	logic keysNow;

	// all three keys held; a partial chord never counts
	assign chordNow = enterKey && dataLeftKey && dataRightKey;
	assign keysNow  = {enterKey, dataLeftKey, dataRightKey, otherKey} != 4'h0;

	// previous key levels for edge detection
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			chordFf <= 1'b0;
			keysFf  <= 1'b0;
		end
		else
		begin
			chordFf <= chordNow;
			keysFf  <= keysNow;
		end
	end

	// one pulse per chord, only in program mode
	assign manualReset = chordNow && !chordFf && programMode;
	assign anyKeyPress = keysNow && !keysFf;
endmodule

// ===== rtl/wsd_show_timer.sv
// hold timer that keeps the fresh stepper values on the displays
`timescale 1ns/1ps
module wsd_show_timer #(
	parameter int SHOW_CYCLES = wsd_pkg::SHOW_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic start,
	output logic      showActive
);
	localparam logic [wsd_pkg::SHOW_CNT_W-1:0] LOAD = wsd_pkg::SHOW_CNT_W'(SHOW_CYCLES);

	logic [wsd_pkg::SHOW_CNT_W-1:0] remainFf;

	// restart wins over countdown so a new reset shows in full
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			remainFf <= '0;
		else if (start)
			remainFf <= LOAD;
		else if (remainFf != '0)
			remainFf <= remainFf - 1'b1;
	end

	assign showActive = remainFf != '0;
endmodule

// ===== rtl/wsd_stepper.sv
// single-counter weld stepper with schedule table and register slave
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - at most fifty steps, reached only with one schedule per step
// - step span equals the count of chained schedules in the step
// - after advancing last step, index above 49 flags end of stepper
// - only the primary initiation decrements; other starts leave counter alone
// - next schedule holding zero count means end of stepper
// - manual reset loads first step index and its programmed count
// - manual reset needs enter held plus both data keys together
// - manual reset ignores the currently selected schedule
// - after a reset both fresh values are shown briefly
// - last step and last count may be written directly at any time
// - such a direct write acts as a stepper reset
// - zero count at final step reading reset command reloads stepper
// - reset command is empty schedule, zero count, off time 99
// - after reload the next sequence starts at the first step
// - with option enabled, each switch activation resets the stepper
// - any key press or emergency stop clears end indication
// - counts up to 9999 are accepted for the down counter
module wsd_stepper #(
	parameter int SHOW_CYCLES = wsd_pkg::SHOW_CYCLES
) (
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic [wsd_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic [31:0]                      avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic                        primary_initiation_input,
	input  wire logic                        second_initiation_input,
	input  wire logic                        third_initiation_input,
	input  wire logic                        external_reset_input,
	input  wire logic                        emergencyStop,
	input  wire logic                        enterKey,
	input  wire logic                        dataLeftKey,
	input  wire logic                        dataRightKey,
	input  wire logic                        otherKey,
	output logic                             seqStart,
	output logic [wsd_pkg::STEP_W-1:0]       seqSchedule,
	output logic                             seqCounted,
	output logic [wsd_pkg::STEP_W-1:0]       lastStep,
	output logic [wsd_pkg::COUNT_W-1:0]      lastCount,
	output logic                             endOfStepper,
	output logic                             displayShow
);
	// schedule table, one entry per schedule
	logic [wsd_pkg::COUNT_W-1:0] cntMem [wsd_pkg::NUM_SCHED];
	logic [wsd_pkg::OFF_W-1:0]   offMem [wsd_pkg::NUM_SCHED];
	logic                        emptyMem [wsd_pkg::NUM_SCHED];
	logic [wsd_pkg::STEP_W-1:0]  chainMem [wsd_pkg::NUM_SCHED];

	logic [1:0]                  ctrlFf;
	logic [wsd_pkg::STEP_W-1:0]  firstStepFf;
	logic [wsd_pkg::STEP_W-1:0]  schedIdxFf;
	logic [wsd_pkg::STEP_W-1:0]  lastStepFf;
	logic [wsd_pkg::COUNT_W-1:0] lastCountFf;
	logic                        endFf;
	logic                        ackFf;
	logic [31:0]                 readdataFf;
	logic                        extOpenFf;
	logic                        seqStartFf;
	logic [wsd_pkg::STEP_W-1:0]  seqScheduleFf;
	logic                        seqCountedFf;
	logic [wsd_pkg::STEP_W-1:0]  nxt_lastStep;
	logic [wsd_pkg::COUNT_W-1:0] nxt_lastCount;
	logic                        nxt_end;
	logic [wsd_pkg::STEP_W:0]    advIdx;
	logic [wsd_pkg::STEP_W-1:0]  advStep;
	logic                        stepperReset;
	logic                        showStart;
	logic                        manualReset;
	logic                        anyKeyPress;
	logic                        extResetPulse;
	logic                        showActive;
	logic                        wrEn;
	logic [31:0]                 readMux;
	logic                        countTick;

	// weld counts above the documented ceiling are clamped
	function automatic logic [wsd_pkg::COUNT_W-1:0] clampCount(
		input logic [wsd_pkg::COUNT_W-1:0] v);
		clampCount = (v > wsd_pkg::MAX_COUNT) ? wsd_pkg::MAX_COUNT : v;
	endfunction

	// schedule index kept inside the table
	function automatic logic [wsd_pkg::STEP_W-1:0] clampStep(
		input logic [wsd_pkg::STEP_W-1:0] v);
		clampStep = (v > wsd_pkg::MAX_SCHED_IDX) ? wsd_pkg::MAX_SCHED_IDX : v;
	endfunction

	// a chain length of zero would stall the stepper, so it counts as one
	function automatic logic [wsd_pkg::STEP_W-1:0] stepSpan(
		input logic [wsd_pkg::STEP_W-1:0] chain);
		stepSpan = (chain == '0) ? wsd_pkg::STEP_W'(1) : chain;
	endfunction

	wsd_panel_keys u_keys (
		.clock        (clock),
		.rst          (rst),
		.enterKey     (enterKey),
		.dataLeftKey  (dataLeftKey),
		.dataRightKey (dataRightKey),
		.otherKey     (otherKey),
		.programMode  (ctrlFf[wsd_pkg::CTRL_PROG]),
		.manualReset  (manualReset),
		.anyKeyPress  (anyKeyPress)
	);

	wsd_show_timer #(
		.SHOW_CYCLES (SHOW_CYCLES)
	) u_show (
		.clock      (clock),
		.rst        (rst),
		.start      (showStart),
		.showActive (showActive)
	);

	// bus handshake: every access waits exactly one cycle
	assign avs_waitrequest = (avs_read || avs_write) && !ackFf;
	assign wrEn            = avs_write && ackFf && (avs_byteenable == 4'hf);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ackFf <= 1'b0;
		else
			ackFf <= (avs_read || avs_write) && !ackFf;
	end

	// read mux; unmapped offsets read as zero
	always_comb
	begin
		readMux = wsd_pkg::RDATA_RST;
		unique case (avs_address)
			wsd_pkg::REG_CTRL:       readMux[1:0] = ctrlFf;
			wsd_pkg::REG_LAST_STEP:  readMux[wsd_pkg::STEP_W-1:0] = lastStepFf;
			wsd_pkg::REG_LAST_COUNT: readMux[wsd_pkg::COUNT_W-1:0] = lastCountFf;
			wsd_pkg::REG_STATUS:
			begin
				readMux[wsd_pkg::STAT_END]  = endFf;
				readMux[wsd_pkg::STAT_SHOW] = showActive;
			end
			wsd_pkg::REG_FIRST_STEP: readMux[wsd_pkg::STEP_W-1:0] = firstStepFf;
			wsd_pkg::REG_SCHED_IDX:  readMux[wsd_pkg::STEP_W-1:0] = schedIdxFf;
			wsd_pkg::REG_SCHED_DATA:
			begin
				readMux[wsd_pkg::COUNT_W-1:0] = cntMem[schedIdxFf];
				readMux[wsd_pkg::SCHED_OFF_LSB +: wsd_pkg::OFF_W] = offMem[schedIdxFf];
				readMux[wsd_pkg::SCHED_EMPTY] = emptyMem[schedIdxFf];
				readMux[wsd_pkg::SCHED_CHAIN_LSB +: wsd_pkg::STEP_W] = chainMem[schedIdxFf];
			end
			default: readMux = wsd_pkg::RDATA_RST;
		endcase
	end

	// read data captured in the wait cycle, valid when waitrequest drops
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			readdataFf <= wsd_pkg::RDATA_RST;
		else if (avs_read && !ackFf)
			readdataFf <= readMux;
	end
	assign avs_readdata = readdataFf;

	// configuration registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ctrlFf      <= wsd_pkg::CTRL_RST;
			firstStepFf <= wsd_pkg::STEP_RST;
			schedIdxFf  <= wsd_pkg::STEP_RST;
		end
		else if (wrEn)
		begin
			if (avs_address == wsd_pkg::REG_CTRL)
				ctrlFf <= avs_writedata[1:0];
			if (avs_address == wsd_pkg::REG_FIRST_STEP)
				firstStepFf <= clampStep(avs_writedata[wsd_pkg::STEP_W-1:0]);
			if (avs_address == wsd_pkg::REG_SCHED_IDX)
				schedIdxFf <= clampStep(avs_writedata[wsd_pkg::STEP_W-1:0]);
		end
	end

	// schedule table writes; no reset, software programs it before use
	always_ff @(posedge clock)
	begin
		if (wrEn && avs_address == wsd_pkg::REG_SCHED_DATA)
		begin
			cntMem[schedIdxFf]   <= clampCount(avs_writedata[wsd_pkg::COUNT_W-1:0]);
			offMem[schedIdxFf]   <= avs_writedata[wsd_pkg::SCHED_OFF_LSB +: wsd_pkg::OFF_W];
			emptyMem[schedIdxFf] <= avs_writedata[wsd_pkg::SCHED_EMPTY];
			chainMem[schedIdxFf] <= avs_writedata[wsd_pkg::SCHED_CHAIN_LSB +: wsd_pkg::STEP_W];
		end
	end

	// external switch is normally closed, so low input means opened
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			extOpenFf <= 1'b0;
		else
			extOpenFf <= !external_reset_input;
	end
	assign extResetPulse = !external_reset_input && !extOpenFf
		&& ctrlFf[wsd_pkg::CTRL_EXT_EN];

	// stepper reset comes from the panel chord or the external switch; both reload the first step
	assign stepperReset = manualReset || extResetPulse;
	// a direct write of either value is a reset too, so it shows them as well
	assign showStart    = stepperReset || (wrEn && (avs_address == wsd_pkg::REG_LAST_STEP
		|| avs_address == wsd_pkg::REG_LAST_COUNT));
	assign countTick    = primary_initiation_input && !endFf;

	// next step index: span of the current chained group
	assign advIdx  = {1'b0, lastStepFf} + {1'b0, stepSpan(chainMem[lastStepFf])};
	assign advStep = advIdx[wsd_pkg::STEP_W-1:0];

	// stepper next state; resets take priority over counting
	always_comb
	begin
		nxt_lastStep  = lastStepFf;
		nxt_lastCount = lastCountFf;
		nxt_end       = endFf;
		if (anyKeyPress || emergencyStop)
			nxt_end = 1'b0;
		if (stepperReset)
		begin
			nxt_lastStep  = firstStepFf;
			nxt_lastCount = cntMem[firstStepFf];
			nxt_end       = 1'b0;
		end
		else if (wrEn && avs_address == wsd_pkg::REG_LAST_STEP)
		begin
			nxt_lastStep = clampStep(avs_writedata[wsd_pkg::STEP_W-1:0]);
			nxt_end      = 1'b0;
		end
		else if (wrEn && avs_address == wsd_pkg::REG_LAST_COUNT)
		begin
			nxt_lastCount = clampCount(avs_writedata[wsd_pkg::COUNT_W-1:0]);
			nxt_end       = 1'b0;
		end
		else if (countTick)
		begin
			if (lastCountFf > wsd_pkg::COUNT_W'(1))
				nxt_lastCount = lastCountFf - 1'b1;
			else if (advIdx > {1'b0, wsd_pkg::MAX_SCHED_IDX})
			begin
				nxt_lastCount = '0;
				nxt_end       = 1'b1;
			end
			else if (cntMem[advStep] == '0)
			begin
				if (emptyMem[advStep] && offMem[advStep] == wsd_pkg::RESET_OFF_TIME)
				begin
					nxt_lastStep  = firstStepFf;
					nxt_lastCount = cntMem[firstStepFf];
				end
				else
				begin
					nxt_lastStep  = advStep;
					nxt_lastCount = '0;
					nxt_end       = 1'b1;
				end
			end
			else
			begin
				nxt_lastStep  = advStep;
				nxt_lastCount = cntMem[advStep];
			end
		end
	end

	// stepper state
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			lastStepFf  <= wsd_pkg::STEP_RST;
			lastCountFf <= wsd_pkg::COUNT_RST;
			endFf       <= 1'b0;
		end
		else
		begin
			lastStepFf  <= nxt_lastStep;
			lastCountFf <= nxt_lastCount;
			endFf       <= nxt_end;
		end
	end

	// sequence launch; the fixed inputs bypass the counter
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			seqStartFf    <= 1'b0;
			seqScheduleFf <= wsd_pkg::STEP_RST;
			seqCountedFf  <= 1'b0;
		end
		else
		begin
			seqStartFf   <= countTick || second_initiation_input || third_initiation_input;
			seqCountedFf <= countTick;
			if (countTick)
				seqScheduleFf <= lastStepFf;
			else if (second_initiation_input)
				seqScheduleFf <= wsd_pkg::SECOND_SCHED;
			else if (third_initiation_input)
				seqScheduleFf <= wsd_pkg::THIRD_SCHED;
		end
	end

	assign seqStart     = seqStartFf;
	assign seqSchedule  = seqScheduleFf;
	assign seqCounted   = seqCountedFf;
	assign lastStep     = lastStepFf;
	assign lastCount    = lastCountFf;
	assign endOfStepper = endFf;
	assign displayShow  = showActive;

	// checks on the stepper behaviour
	a_count_decrement: assert property (@(posedge clock) disable iff (rst)
		countTick && !stepperReset && !wrEn && lastCountFf > 14'h0001
		|=> lastCountFf == $past(lastCountFf) - 14'h0001)
		else $error("primary start did not decrement the count");
	a_other_no_dec: assert property (@(posedge clock) disable iff (rst)
		!primary_initiation_input && !stepperReset && !wrEn
		|=> lastCountFf == $past(lastCountFf))
		else $error("count changed without a primary start");
	a_chord_needed: assert property (@(posedge clock) disable iff (rst)
		!(enterKey && dataLeftKey && dataRightKey && ctrlFf[wsd_pkg::CTRL_PROG])
		&& !extResetPulse && !countTick && !wrEn
		|=> lastStepFf == $past(lastStepFf))
		else $error("step changed without full key chord");
	a_reset_loads: assert property (@(posedge clock) disable iff (rst)
		stepperReset |=> lastStepFf == $past(firstStepFf) && !endFf)
		else $error("reset did not load the first step");
	a_end_overflow: assert property (@(posedge clock) disable iff (rst)
		countTick && !stepperReset && !wrEn && lastCountFf <= 14'h0001
		&& advIdx > 7'h31 |=> endFf && lastCountFf == 14'h0000)
		else $error("step past 49 did not end the stepper");
	a_show_hold: assert property (@(posedge clock) disable iff (rst)
		stepperReset |=> displayShow && lastStep == $past(firstStepFf))
		else $error("display hold missing after reset");
	a_end_clear: assert property (@(posedge clock) disable iff (rst)
		(anyKeyPress || emergencyStop) && !countTick |=> !endFf)
		else $error("key press did not clear end indication");
	a_count_cap: assert property (@(posedge clock) disable iff (rst)
		lastCountFf <= 14'h270f)
		else $error("count above 9999");
	a_ext_reset: assert property (@(posedge clock) disable iff (rst)
		$fell(external_reset_input) && ctrlFf[wsd_pkg::CTRL_EXT_EN]
		|=> lastStepFf == $past(firstStepFf))
		else $error("external switch did not reset stepper");
	a_bus_wait: assert property (@(posedge clock) disable iff (rst)
		(avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest || !(avs_read || avs_write))
		else $error("waitrequest held for more than one cycle");
endmodule

// ===== testbench/wsd_panel_model.sv
// front panel keys plus initiation and reset switches around the stepper
`timescale 1ns/1ps
module wsd_panel_model (
	input  wire logic clock,
	output logic      primary_initiation_input,
	output logic      second_initiation_input,
	output logic      third_initiation_input,
	output logic      external_reset_input,
	output logic      emergencyStop,
	output logic      enterKey,
	output logic      dataLeftKey,
	output logic      dataRightKey,
	output logic      otherKey
);
	// all idle at time zero; the reset switch rests closed
	initial
	begin
		{primary_initiation_input, second_initiation_input, third_initiation_input} = 3'h0;
		{enterKey, dataLeftKey, dataRightKey, otherKey} = 4'h0;
		emergencyStop = 1'b0;
		external_reset_input = 1'b1;
	end

	// keys held two cycles so a chord is seen whole in one cycle
	task automatic press(input logic [3:0] keys);
		@(posedge clock);
		{enterKey, dataLeftKey, dataRightKey, otherKey} <= keys;
		repeat (2) @(posedge clock);
		{enterKey, dataLeftKey, dataRightKey, otherKey} <= 4'h0;
	endtask

	// one-cycle start pulse on input 1, 2 or 3
	task automatic pulse(input int which);
		@(posedge clock);
		{primary_initiation_input, second_initiation_input,
			third_initiation_input} <= 3'h4 >> (which - 1);
		@(posedge clock);
		{primary_initiation_input, second_initiation_input, third_initiation_input} <= 3'h0;
	endtask

	// emergency stop held for two cycles
	task automatic stop;
		@(posedge clock);
		emergencyStop <= 1'b1;
		repeat (2) @(posedge clock);
		emergencyStop <= 1'b0;
	endtask

	// momentary opening of the normally closed switch
	task automatic openSwitch;
		@(posedge clock);
		external_reset_input <= 1'b0;
		repeat (2) @(posedge clock);
		external_reset_input <= 1'b1;
	endtask
endmodule

// ===== testbench/wsd_stepper_tb.sv
// self-checking bench for the weld step down counter
`timescale 1ns/1ps
module wsd_stepper_tb;
	localparam int LIMIT = 4000;
	logic        clock = 1'b0;
	logic        rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        primary_initiation_input;
	logic        second_initiation_input;
	logic        third_initiation_input;
	logic        external_reset_input;
	logic        emergencyStop;
	logic        enterKey;
	logic        dataLeftKey;
	logic        dataRightKey;
	logic        otherKey;
	logic        seqStart;
	logic [5:0]  seqSchedule;
	logic        seqCounted;
	logic [5:0]  lastStep;
	logic [13:0] lastCount;
	logic        endOfStepper;
	logic        displayShow;
	int          errors = 0;
	int          checks = 0;
	int          cycles = 0;

	// short display hold keeps the run brief
	wsd_stepper #(.SHOW_CYCLES(4)) dut (
		.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.primary_initiation_input(primary_initiation_input),
		.second_initiation_input(second_initiation_input),
		.third_initiation_input(third_initiation_input),
		.external_reset_input(external_reset_input), .emergencyStop(emergencyStop),
		.enterKey(enterKey), .dataLeftKey(dataLeftKey), .dataRightKey(dataRightKey),
		.otherKey(otherKey), .seqStart(seqStart), .seqSchedule(seqSchedule),
		.seqCounted(seqCounted), .lastStep(lastStep), .lastCount(lastCount),
		.endOfStepper(endOfStepper), .displayShow(displayShow)
	);

	wsd_panel_model panel (
		.clock(clock), .primary_initiation_input(primary_initiation_input),
		.second_initiation_input(second_initiation_input),
		.third_initiation_input(third_initiation_input),
		.external_reset_input(external_reset_input), .emergencyStop(emergencyStop),
		.enterKey(enterKey), .dataLeftKey(dataLeftKey), .dataRightKey(dataRightKey),
		.otherKey(otherKey)
	);

	// 40 MHz clock
	always #12.5 clock = ~clock;

	// a hang counts as a mismatch and ends the run
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	// one transfer; the request stands until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		forever
		begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [31:0] e, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(q, e, what);
	endtask

	// table entries are not reset, so every used one is written
	task automatic sched(input logic [5:0] idx, input logic [13:0] cnt,
		input logic [6:0] off, input logic empty, input logic [5:0] chain);
		wr(wsd_pkg::REG_SCHED_IDX, 32'(idx));
		wr(wsd_pkg::REG_SCHED_DATA, {4'h0, chain, empty, off, cnt});
	endtask

	// look one edge later, off the edge itself
	task automatic settle;
		@(posedge clock);
		#1;
	endtask

	task automatic state(input logic [5:0] s, input logic [13:0] c, input logic e);
		check(32'(lastStep), 32'(s), "step");
		check(32'(lastCount), 32'(c), "count");
		check(32'(endOfStepper), 32'(e), "end");
	endtask

	// start pulse, then judge the answer in the following cycle
	task automatic fire(input int which, input logic st, input logic [5:0] sch,
		input logic cnt);
		panel.pulse(which);
		#1;
		check(32'(seqStart), 32'(st), "start");
		if (st)
		begin
			check(32'(seqSchedule), 32'(sch), "schedule");
			check(32'(seqCounted), 32'(cnt), "counted");
		end
	endtask

	task automatic run_reset;
		settle();
		state(6'h00, 14'h0000, 1'b0);
		rdchk(wsd_pkg::REG_STATUS, 32'h0000_0000, "status");
		rdchk(5'h1c, 32'h0000_0000, "unmapped");
		@(posedge clock);
		avs_byteenable <= 4'h3;
		wr(wsd_pkg::REG_LAST_COUNT, 32'h0000_0007);
		avs_byteenable <= 4'hf;
		rdchk(wsd_pkg::REG_LAST_COUNT, 32'h0000_0000, "partial write");
	endtask

	task automatic run_count;
		logic [3:0] part [3] = '{4'hc, 4'ha, 4'h6};
		sched(6'h00, 14'h0003, 7'h00, 1'b0, 6'h02);
		sched(6'h02, 14'h0002, 7'h00, 1'b0, 6'h01);
		sched(6'h03, 14'h0000, 7'h00, 1'b0, 6'h01);
		sched(6'h09, 14'h0007, 7'h00, 1'b0, 6'h01);
		wr(wsd_pkg::REG_FIRST_STEP, 32'h0000_0000);
		wr(wsd_pkg::REG_CTRL, 32'h0000_0002);
		// partial chords must leave the stepper alone
		foreach (part[i])
		begin
			panel.press(part[i]);
			settle();
			state(6'h00, 14'h0000, 1'b0);
		end
		panel.press(4'he);
		settle();
		state(6'h00, 14'h0003, 1'b0);
		check(32'(displayShow), 32'h0000_0001, "show");
		repeat (5) @(posedge clock);
		settle();
		check(32'(displayShow), 32'h0000_0000, "show off");
		wr(wsd_pkg::REG_CTRL, 32'h0000_0000);
		// full chord outside program mode must not reset
		panel.press(4'he);
		settle();
		state(6'h00, 14'h0003, 1'b0);
		fire(1, 1'b1, 6'h00, 1'b1);
		state(6'h00, 14'h0002, 1'b0);
		fire(2, 1'b1, wsd_pkg::SECOND_SCHED, 1'b0);
		state(6'h00, 14'h0002, 1'b0);
		fire(3, 1'b1, wsd_pkg::THIRD_SCHED, 1'b0);
		state(6'h00, 14'h0002, 1'b0);
		fire(1, 1'b1, 6'h00, 1'b1);
		fire(1, 1'b1, 6'h00, 1'b1);
		state(6'h02, 14'h0002, 1'b0);
		fire(1, 1'b1, 6'h02, 1'b1);
		fire(1, 1'b1, 6'h02, 1'b1);
		state(6'h03, 14'h0000, 1'b1);
		fire(1, 1'b0, 6'h00, 1'b0);
	endtask

	task automatic run_reload;
		sched(6'h03, 14'h0000, 7'h63, 1'b1, 6'h01);
		wr(wsd_pkg::REG_LAST_STEP, 32'h0000_0002);
		wr(wsd_pkg::REG_LAST_COUNT, 32'h0000_0001);
		settle();
		state(6'h02, 14'h0001, 1'b0);
		check(32'(displayShow), 32'h0000_0001, "show");
		fire(1, 1'b1, 6'h02, 1'b1);
		state(6'h00, 14'h0003, 1'b0);
		fire(1, 1'b1, 6'h00, 1'b1);
		state(6'h00, 14'h0002, 1'b0);
	endtask

	task automatic run_limit;
		sched(6'h31, 14'h0005, 7'h00, 1'b0, 6'h01);
		wr(wsd_pkg::REG_LAST_STEP, 32'h0000_0031);
		wr(wsd_pkg::REG_LAST_COUNT, 32'h0000_0001);
		fire(1, 1'b1, 6'h31, 1'b1);
		check(32'(endOfStepper), 32'h0000_0001, "end");
		check(32'(lastCount), 32'h0000_0000, "count");
		panel.stop();
		settle();
		check(32'(endOfStepper), 32'h0000_0000, "end");
		wr(wsd_pkg::REG_LAST_STEP, 32'h0000_003f);
		rdchk(wsd_pkg::REG_LAST_STEP, 32'h0000_0031, "step clamp");
		wr(wsd_pkg::REG_LAST_COUNT, 32'h0000_270f);
		rdchk(wsd_pkg::REG_LAST_COUNT, 32'h0000_270f, "count max");
		// switch ignored while the option is off
		panel.openSwitch();
		settle();
		state(6'h31, 14'h270f, 1'b0);
		wr(wsd_pkg::REG_CTRL, 32'h0000_0001);
		panel.openSwitch();
		settle();
		state(6'h00, 14'h0003, 1'b0);
	endtask

	initial
	begin
		rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		run_reset();
		run_count();
		run_reload();
		run_limit();
		report_and_stop();
	end
endmodule
